/* File: design/ciex_map.svh */
`ifndef CIEX_MAP_SVH
`define CIEX_MAP_SVH

// Register byte offsets on the APB bus.
`define CIEX_ADDR_INSTR 12'h000
`define CIEX_ADDR_ACCUM 12'h004
`define CIEX_ADDR_PCLATCH 12'h008
`define CIEX_ADDR_PC 12'h00C
`define CIEX_ADDR_STATUS 12'h010
`define CIEX_ADDR_STACK 12'h014
`define CIEX_ADDR_FSEL 12'h018
`define CIEX_ADDR_FDATA 12'h01C
`define CIEX_ADDR_WDT 12'h020

// Instruction word fields.
`define CIEX_INSTR_OP_LSB 0
`define CIEX_INSTR_OP_MSB 3
`define CIEX_INSTR_FA_LSB 4
`define CIEX_INSTR_FA_MSB 10
`define CIEX_INSTR_DEST_BIT 11

// Operation codes.
`define CIEX_OPC_NOP 4'h0
`define CIEX_OPC_CALL_ACC 4'h1
`define CIEX_OPC_CLR_FILE 4'h2
`define CIEX_OPC_CLR_ACC 4'h3
`define CIEX_OPC_CLR_WDOG 4'h4
`define CIEX_OPC_CPL_FILE 4'h5
`define CIEX_OPC_DEC_FILE 4'h6
`define CIEX_OPC_DEC_SKIP 4'h7
`define CIEX_OPC_INC_SKIP 4'h8

// Status register bit positions.
`define CIEX_ST_ZERO_BIT 0
`define CIEX_ST_PDN_BIT 1
`define CIEX_ST_TON_BIT 2
`define CIEX_ST_BUSY_BIT 3

// Reset values.
`define CIEX_PC_RST 15'h0000
`define CIEX_ACCUM_RST 8'h00
`define CIEX_PCLATCH_RST 7'h00
`define CIEX_SP_RST 4'h0

// Storage depths and watchdog counts.
`define CIEX_FILE_DEPTH 128
`define CIEX_STACK_DEPTH 16
`define CIEX_WDT_PRE_MAX 8'hFF
`define CIEX_WDT_CNT_MAX 8'hFF

`endif

/* File: design/ciex_pkg.sv */
package ciex_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SECOND} ciex_state_t;
endpackage : ciex_pkg

/* File: design/ciex_alu.sv */
`timescale 1ns/1ps
`include "ciex_map.svh"
module ciex_alu (
  input wire logic [3:0] op,
  input wire logic dest,
  input wire logic [7:0] file_val,
  output logic [7:0] result,
  output logic res_zero,
  output logic to_file,
  output logic to_accum,
  output logic upd_zero,
  output logic is_skip
);
  logic is_clr_file;
  logic is_clr_acc;
  logic is_cpl;
  logic is_dec;
  logic is_inc;
  logic routed;

  assign is_clr_file = op == `CIEX_OPC_CLR_FILE;
  assign is_clr_acc = op == `CIEX_OPC_CLR_ACC;
  assign is_cpl = op == `CIEX_OPC_CPL_FILE;
  assign is_dec = (op == `CIEX_OPC_DEC_FILE) || (op == `CIEX_OPC_DEC_SKIP);
  assign is_inc = op == `CIEX_OPC_INC_SKIP;
  assign routed = is_cpl | is_dec | is_inc;

  assign result = is_cpl ? ~file_val :
                  is_dec ? file_val - 8'h01 :
                  is_inc ? file_val + 8'h01 : 8'h00;
  assign res_zero = result == 8'h00;
  assign to_file = is_clr_file | (routed & dest);
  assign to_accum = is_clr_acc | (routed & ~dest);
  assign upd_zero = is_clr_file | is_clr_acc | is_cpl | (op == `CIEX_OPC_DEC_FILE);
  // Both skip forms test the result.
  assign is_skip = (op == `CIEX_OPC_DEC_SKIP) || is_inc;
endmodule : ciex_alu

/* File: design/ciex_core.sv */
// Overview of operation
// - call_via_accum pushes return, loads PC from latch and accumulator.
// - call_via_accum takes two cycles, flags unchanged.
// - clear_file_reg zeroes file register, sets zero.
// - clear_accum zeroes accumulator, sets zero flag.
// - clear_watchdog clears watchdog count and prescaler.
// - clear_watchdog sets timeout and powerdown flags.
// - complement_file_reg inverts file, updates zero flag.
// - dest_select zero to accumulator, one to file.
// - decrement_file_reg subtracts one, updates zero flag.
// - decrement_skip_zero subtracts, skips on zero, no flags.
// - increment_skip_zero adds, skips on zero, no flags.
// - Taken skip runs a NOP, two cycles.
// - Pushed return address is current address plus one.
`timescale 1ns/1ps
`include "ciex_map.svh"
module ciex_core
  import ciex_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic [7:0] file_mem [0:`CIEX_FILE_DEPTH-1];
  logic [14:0] stack_mem [0:`CIEX_STACK_DEPTH-1];
  ciex_state_t state_reg;
  ciex_state_t state_next;
  logic [3:0] op_reg;
  logic [6:0] faddr_reg;
  logic dest_reg;
  logic [7:0] w_reg;
  logic [6:0] latch_reg;
  logic [14:0] pc_reg;
  logic [14:0] pc_next;
  logic [3:0] sp_reg;
  logic zero_reg;
  logic timeout_n_reg;
  logic powerdown_n_reg;
  logic [6:0] fsel_reg;
  logic [7:0] wdt_pre_reg;
  logic [7:0] wdt_cnt_reg;
  logic [31:0] rd_mux;
  logic [7:0] alu_result;
  logic alu_zero;
  logic alu_to_file;
  logic alu_to_accum;
  logic alu_upd_zero;
  logic alu_skip;

  wire setup_phase = psel & ~penable;
  wire apb_write = psel & penable & pwrite & pready;
  wire hit_instr = paddr == `CIEX_ADDR_INSTR;
  wire hit_accum = paddr == `CIEX_ADDR_ACCUM;
  wire hit_latch = paddr == `CIEX_ADDR_PCLATCH;
  wire hit_pc = paddr == `CIEX_ADDR_PC;
  wire hit_status = paddr == `CIEX_ADDR_STATUS;
  wire hit_stack = paddr == `CIEX_ADDR_STACK;
  wire hit_fsel = paddr == `CIEX_ADDR_FSEL;
  wire hit_fdata = paddr == `CIEX_ADDR_FDATA;
  wire hit_wdt = paddr == `CIEX_ADDR_WDT;
  wire hit_any = hit_instr | hit_accum | hit_latch | hit_pc | hit_status | hit_stack | hit_fsel | hit_fdata | hit_wdt;

  // An instruction written while the core is busy is dropped, so software polls the busy bit first.
  wire issue = apb_write & hit_instr & (state_reg == ST_IDLE);
  wire exec_cyc = state_reg == ST_EXEC;
  wire second_cyc = state_reg == ST_SECOND;
  wire is_call = op_reg == `CIEX_OPC_CALL_ACC;
  wire call_exec = exec_cyc & is_call;
  wire skip_taken = exec_cyc & alu_skip & alu_zero;
  wire wdt_clear = exec_cyc & (op_reg == `CIEX_OPC_CLR_WDOG);
  wire wdt_tick = wdt_pre_reg == `CIEX_WDT_PRE_MAX;
  wire wdt_expire = wdt_tick & (wdt_cnt_reg == `CIEX_WDT_CNT_MAX);
  wire exec_file_wr = exec_cyc & alu_to_file;
  wire exec_w_wr = exec_cyc & alu_to_accum;
  wire [7:0] file_val = file_mem[faddr_reg];
  wire [14:0] pc_plus1 = pc_reg + 15'h0001;
  wire [14:0] stack_top = stack_mem[sp_reg - 4'h1];

  ciex_alu u_alu (
    .op(op_reg),
    .dest(dest_reg),
    .file_val(file_val),
    .result(alu_result),
    .res_zero(alu_zero),
    .to_file(alu_to_file),
    .to_accum(alu_to_accum),
    .upd_zero(alu_upd_zero),
    .is_skip(alu_skip)
  );

  // Call and taken skip get a second cycle.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (issue) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (is_call || skip_taken) begin
          state_next = ST_SECOND;
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_SECOND: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Second call cycle loads PC from latch and accumulator.
  // Second skip cycle steps over the discarded word.
  always_comb begin
    pc_next = pc_reg;
    if (exec_cyc && !is_call) begin
      pc_next = pc_plus1;
    end else if (second_cyc && is_call) begin
      pc_next = {latch_reg, w_reg};
    end else if (second_cyc) begin
      pc_next = pc_plus1;
    end else if (apb_write && hit_pc) begin
      pc_next = pwdata[14:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      pc_reg <= `CIEX_PC_RST;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_reg <= `CIEX_OPC_NOP;
      faddr_reg <= 7'h00;
      dest_reg <= 1'b0;
    end else if (issue) begin
      op_reg <= pwdata[`CIEX_INSTR_OP_MSB:`CIEX_INSTR_OP_LSB];
      faddr_reg <= pwdata[`CIEX_INSTR_FA_MSB:`CIEX_INSTR_FA_LSB];
      dest_reg <= pwdata[`CIEX_INSTR_DEST_BIT];
    end
  end

  // Accumulator takes the core result first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_reg <= `CIEX_ACCUM_RST;
    end else if (exec_w_wr) begin
      w_reg <= alu_result;
    end else if (apb_write && hit_accum) begin
      w_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_reg <= `CIEX_PCLATCH_RST;
      fsel_reg <= 7'h00;
    end else begin
      if (apb_write && hit_latch) begin
        latch_reg <= pwdata[6:0];
      end
      if (apb_write && hit_fsel) begin
        fsel_reg <= pwdata[6:0];
      end
    end
  end

  // File write port, core before bus.
  always_ff @(posedge pclk) begin
    if (exec_file_wr) begin
      file_mem[faddr_reg] <= alu_result;
    end else if (apb_write && hit_fdata) begin
      file_mem[fsel_reg] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk) begin
    if (call_exec) begin
      stack_mem[sp_reg] <= pc_plus1;
    end
  end

  // The stack pointer wraps, so a seventeenth push silently overwrites the oldest entry.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_reg <= `CIEX_SP_RST;
    end else if (call_exec) begin
      sp_reg <= sp_reg + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_reg <= 1'b0;
    end else if (exec_cyc && alu_upd_zero) begin
      zero_reg <= alu_zero;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_pre_reg <= 8'h00;
      wdt_cnt_reg <= 8'h00;
    end else if (wdt_clear) begin
      wdt_pre_reg <= 8'h00;
      wdt_cnt_reg <= 8'h00;
    end else begin
      wdt_pre_reg <= wdt_pre_reg + 8'h01;
      if (wdt_tick) begin
        wdt_cnt_reg <= wdt_cnt_reg + 8'h01;
      end
    end
  end

  // Clear sets both flags and beats an expiry in the same cycle, since it restarts the count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_n_reg <= 1'b1;
      powerdown_n_reg <= 1'b1;
    end else if (wdt_clear) begin
      timeout_n_reg <= 1'b1;
      powerdown_n_reg <= 1'b1;
    end else if (wdt_expire) begin
      timeout_n_reg <= 1'b0;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_instr) begin
      rd_mux = {20'h00000, dest_reg, faddr_reg, op_reg};
    end else if (hit_accum) begin
      rd_mux = {24'h000000, w_reg};
    end else if (hit_latch) begin
      rd_mux = {25'h0000000, latch_reg};
    end else if (hit_pc) begin
      rd_mux = {17'h00000, pc_reg};
    end else if (hit_status) begin
      rd_mux[`CIEX_ST_ZERO_BIT] = zero_reg;
      rd_mux[`CIEX_ST_PDN_BIT] = powerdown_n_reg;
      rd_mux[`CIEX_ST_TON_BIT] = timeout_n_reg;
      rd_mux[`CIEX_ST_BUSY_BIT] = state_reg != ST_IDLE;
    end else if (hit_stack) begin
      rd_mux = {12'h000, sp_reg, 1'b0, stack_top};
    end else if (hit_fsel) begin
      rd_mux = {25'h0000000, fsel_reg};
    end else if (hit_fdata) begin
      rd_mux = {24'h000000, file_mem[fsel_reg]};
    end else if (hit_wdt) begin
      rd_mux = {16'h0000, wdt_pre_reg, wdt_cnt_reg};
    end
  end

  // Read data is captured in the setup cycle so the access phase always completes in one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= (setup_phase && !pwrite) ? rd_mux : 32'h0000_0000;
      pready <= setup_phase;
      pslverr <= setup_phase & ~hit_any;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_call_cycles;
    call_exec ##1 second_cyc;
  endsequence
  sequence s_skip_cycles;
    skip_taken ##1 second_cyc;
  endsequence

  a_call_push_addr: assert property (
    call_exec |=> stack_top == $past(pc_reg) + 15'h0001)
    else $error("call pushed the wrong return address");

  a_call_pc_load: assert property (
    s_call_cycles |=> pc_reg == {$past(latch_reg), $past(w_reg)})
    else $error("call loaded the wrong program counter");

  a_call_two_cycles: assert property (
    call_exec |=> (second_cyc && $stable(zero_reg) && ($stable(timeout_n_reg) || $past(wdt_expire)))
      ##1 (state_reg == ST_IDLE && $stable(zero_reg)))
    else $error("call did not take two cycles with flags kept");

  a_clr_file_result: assert property (
    exec_cyc && op_reg == `CIEX_OPC_CLR_FILE |=> file_mem[$past(faddr_reg)] == 8'h00 && zero_reg)
    else $error("file clear did not zero register and set zero");

  a_clr_acc_result: assert property (
    exec_cyc && op_reg == `CIEX_OPC_CLR_ACC |=> w_reg == 8'h00 && zero_reg)
    else $error("accumulator clear failed");

  a_wdt_restart: assert property (
    wdt_clear |=> wdt_cnt_reg == 8'h00 && wdt_pre_reg == 8'h00 ##1 wdt_pre_reg == 8'h01)
    else $error("watchdog clear did not restart counters");

  a_wdt_flags_set: assert property (
    wdt_clear |=> timeout_n_reg && powerdown_n_reg)
    else $error("watchdog clear did not set flags");

  a_cpl_to_accum: assert property (
    exec_cyc && op_reg == `CIEX_OPC_CPL_FILE && !dest_reg |=> w_reg == ~$past(file_val))
    else $error("complement result wrong");

  a_dest_file_kept: assert property (
    exec_cyc && dest_reg && op_reg == `CIEX_OPC_DEC_FILE |=> file_mem[$past(faddr_reg)] == $past(file_val) - 8'h01
      && (w_reg == $past(w_reg) || $past(apb_write && hit_accum)))
    else $error("file destination routing wrong");

  a_dec_to_accum: assert property (
    exec_cyc && op_reg == `CIEX_OPC_DEC_FILE && !dest_reg |=> w_reg == $past(file_val) - 8'h01)
    else $error("decrement result wrong");

  a_skip_no_flags: assert property (
    exec_cyc && alu_skip |=> $stable(zero_reg))
    else $error("skip instruction changed zero flag");

  a_skip_not_taken: assert property (
    exec_cyc && alu_skip && !alu_zero |=> state_reg == ST_IDLE && pc_reg == $past(pc_reg) + 15'h0001)
    else $error("skip taken on non-zero result");

  a_skip_nop_cycle: assert property (
    s_skip_cycles |=> state_reg == ST_IDLE && pc_reg == $past(pc_reg, 2) + 15'h0002)
    else $error("taken skip did not run two cycles");

  a_zero_tracks: assert property (
    exec_cyc && alu_upd_zero |=> zero_reg == ($past(alu_result) == 8'h00))
    else $error("zero flag disagrees with result");

  a_apb_one_wait: assert property (
    setup_phase |=> pready ##1 (!pready || $past(setup_phase)))
    else $error("bus answer not in the access cycle");
endmodule : ciex_core

/* File: tb/ciex_core_test.sv */
`timescale 1ns/1ps
`include "ciex_map.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin failures++; $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module ciex_core_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int checked = 0;

  always #5 pclk = ~pclk;

  ciex_core dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  task give_verdict;
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Entered just after a rising edge; one idle cycle follows each transfer.
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] d, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      give_verdict();
    end
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd, err);
  endtask : wr

  task rdv(input logic [11:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0000_0000, d, err);
  endtask : rdv

  function logic [11:0] enc(input logic [3:0] op, input logic [6:0] fa, input logic d);
    enc = {d, fa, op};
  endfunction : enc

  task fset(input logic [6:0] a, input logic [7:0] v);
    wr(`CIEX_ADDR_FSEL, {25'h0, a});
    wr(`CIEX_ADDR_FDATA, {24'h0, v});
  endtask : fset

  task fget(input logic [6:0] a, output logic [31:0] d);
    wr(`CIEX_ADDR_FSEL, {25'h0, a});
    rdv(`CIEX_ADDR_FDATA, d);
  endtask : fget

  // Starts from a known PC so the advance can be judged without reading it back first.
  task issue(input logic [11:0] ins, input logic [14:0] exp_pc);
    int n;
    n = 0;
    wr(`CIEX_ADDR_PC, 32'h0000_0100);
    wr(`CIEX_ADDR_INSTR, {20'h0, ins});
    rdv(`CIEX_ADDR_STATUS, rd);
    // The first poll meets the second cycle, so only the two-cycle forms still show busy there.
    `CHK("busy_second", exp_pc != 15'h0101, rd[3])
    do begin
      rdv(`CIEX_ADDR_STATUS, rd);
      n++;
    end while (rd[3] !== 1'b0 && n < 10);
    if (rd[3] !== 1'b0) begin
      failures++;
      give_verdict();
    end
    rdv(`CIEX_ADDR_PC, rd);
    `CHK("pc", {17'h0, exp_pc}, rd)
  endtask : issue

  task expect_reg(input string nm, input logic [11:0] a, input logic [31:0] ex);
    rdv(a, rd);
    `CHK(nm, ex, rd)
  endtask : expect_reg

  task t_reset;
    expect_reg("pc_rst", `CIEX_ADDR_PC, 32'h0000_0000);
    expect_reg("status_rst", `CIEX_ADDR_STATUS, 32'h0000_0006);
    rdv(12'h100, rd);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_data", 32'h0000_0000, rd)
  endtask : t_reset

  task t_clear;
    wr(`CIEX_ADDR_ACCUM, 32'h0000_005A);
    issue(enc(`CIEX_OPC_CLR_ACC, 7'h00, 1'b0), 15'h0101);
    expect_reg("accum_clr", `CIEX_ADDR_ACCUM, 32'h0000_0000);
    expect_reg("z_clr_acc", `CIEX_ADDR_STATUS, 32'h0000_0007);
    fset(7'h7F, 8'hA5);
    issue(enc(`CIEX_OPC_DEC_FILE, 7'h7F, 1'b0), 15'h0101);
    expect_reg("accum_dec", `CIEX_ADDR_ACCUM, 32'h0000_00A4);
    expect_reg("z_dec", `CIEX_ADDR_STATUS, 32'h0000_0006);
    issue(enc(`CIEX_OPC_CLR_FILE, 7'h7F, 1'b0), 15'h0101);
    fget(7'h7F, rd);
    `CHK("file_clr", 32'h0000_0000, rd)
    expect_reg("z_clr_file", `CIEX_ADDR_STATUS, 32'h0000_0007);
  endtask : t_clear

  task t_complement_file_reg;
    fset(7'h05, 8'hFF);
    issue(enc(`CIEX_OPC_CPL_FILE, 7'h05, 1'b0), 15'h0101);
    expect_reg("accum_cpl", `CIEX_ADDR_ACCUM, 32'h0000_0000);
    fget(7'h05, rd);
    `CHK("file_cpl_kept", 32'h0000_00FF, rd)
    fset(7'h05, 8'h0F);
    issue(enc(`CIEX_OPC_CPL_FILE, 7'h05, 1'b1), 15'h0101);
    fget(7'h05, rd);
    `CHK("file_cpl", 32'h0000_00F0, rd)
    expect_reg("z_cpl", `CIEX_ADDR_STATUS, 32'h0000_0006);
  endtask : t_complement_file_reg

  task t_dec;
    fset(7'h01, 8'h01);
    issue(enc(`CIEX_OPC_DEC_FILE, 7'h01, 1'b1), 15'h0101);
    fget(7'h01, rd);
    `CHK("file_dec", 32'h0000_0000, rd)
    expect_reg("z_dec_zero", `CIEX_ADDR_STATUS, 32'h0000_0007);
    issue(enc(`CIEX_OPC_DEC_FILE, 7'h01, 1'b0), 15'h0101);
    expect_reg("accum_wrap", `CIEX_ADDR_ACCUM, 32'h0000_00FF);
    expect_reg("z_dec_nz", `CIEX_ADDR_STATUS, 32'h0000_0006);
  endtask : t_dec

  // The zero flag is clear on entry, so a skip result of zero must not set it.
  task t_skip;
    fset(7'h02, 8'h01);
    issue(enc(`CIEX_OPC_DEC_SKIP, 7'h02, 1'b1), 15'h0102);
    fget(7'h02, rd);
    `CHK("file_dec_skip", 32'h0000_0000, rd)
    fset(7'h03, 8'hFF);
    issue(enc(`CIEX_OPC_INC_SKIP, 7'h03, 1'b0), 15'h0102);
    expect_reg("accum_inc_skip", `CIEX_ADDR_ACCUM, 32'h0000_0000);
    expect_reg("z_skip", `CIEX_ADDR_STATUS, 32'h0000_0006);
    fset(7'h04, 8'h10);
    issue(enc(`CIEX_OPC_INC_SKIP, 7'h04, 1'b1), 15'h0101);
    fget(7'h04, rd);
    `CHK("file_inc_skip", 32'h0000_0011, rd)
    issue(enc(`CIEX_OPC_DEC_SKIP, 7'h04, 1'b0), 15'h0101);
    expect_reg("accum_dec_skip", `CIEX_ADDR_ACCUM, 32'h0000_0010);
  endtask : t_skip

  task t_call;
    wr(`CIEX_ADDR_PCLATCH, 32'h0000_0055);
    wr(`CIEX_ADDR_ACCUM, 32'h0000_00A3);
    issue(enc(`CIEX_OPC_CALL_ACC, 7'h00, 1'b0), 15'h55A3);
    rdv(`CIEX_ADDR_STACK, rd);
    `CHK("ret_addr", 15'h0101, rd[14:0])
    `CHK("stack_ptr", 4'h1, rd[19:16])
    expect_reg("z_call", `CIEX_ADDR_STATUS, 32'h0000_0006);
    // A plain no-operation only steps the counter and pushes nothing.
    issue(enc(`CIEX_OPC_NOP, 7'h00, 1'b0), 15'h0101);
    expect_reg("accum_nop", `CIEX_ADDR_ACCUM, 32'h0000_00A3);
    rdv(`CIEX_ADDR_STACK, rd);
    `CHK("stack_ptr_nop", 4'h1, rd[19:16])
  endtask : t_call

  // Waits past the full prescaler and count span so the timeout flag has dropped.
  task t_wdt;
    repeat (65600) @(posedge pclk);
    rdv(`CIEX_ADDR_STATUS, rd);
    `CHK("timed_out", 1'b0, rd[2])
    issue(enc(`CIEX_OPC_CLR_WDOG, 7'h00, 1'b0), 15'h0101);
    rdv(`CIEX_ADDR_STATUS, rd);
    `CHK("flags_set", 2'b11, rd[2:1])
    rdv(`CIEX_ADDR_WDT, rd);
    `CHK("wdt_count", 8'h00, rd[7:0])
    `CHK("wdt_pre_low", 1'b1, rd[15:8] < 8'h20)
  endtask : t_wdt

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_clear();
    t_complement_file_reg();
    t_dec();
    t_skip();
    t_call();
    t_wdt();
    give_verdict();
  end
endmodule : ciex_core_test
